// [modrate_defs.svh]
// Register offsets, field limits, reset values and code constants for the modulator rate block.
// Assumes inclusion by bare name from the package only; the design modules see its macros through it.
`ifndef MODRATE_DEFS_SVH
`define MODRATE_DEFS_SVH

// Register byte offsets
`define OFS_FSK_CLK      8'h00
`define OFS_ASK_CLK      8'h04
`define OFS_TEST_SEL     8'h08
`define OFS_OSC_CTRL     8'h0c
`define OFS_DEV_CTRL     8'h10
`define OFS_AMP_BIAS     8'h14
`define OFS_STATUS       8'h18

// Field limits
`define FSK_EXP_MAX      3'h5
`define ASK_EXP_MAX      2'h3
`define FSK_EXP_BASE     4'h3
`define ASK_EXP_BASE     4'h5
`define DEV_ATT_MAX      3'h4

// Reset values
`define RST_FSK_DIV      6'h01
`define RST_ASK_DIV      6'h01

// Spreading patterns
`define ALT_PATTERN      8'h55
`define PN_PATTERN       15'h7ac8
`define PN_LEN           4'he
`define ALT_LEN          4'h7

// Test output codes
`define TOS_GND          3'h0
`define TOS_FB_DIV       3'h1
`define TOS_REF_DIV      3'h2
`define TOS_MOD_OUT      3'h3
`define TOS_BANDGAP      3'h4
`define TOS_UNUSED       3'h5
`define TOS_DIG_SUPPLY   3'h6
`define TOS_PKT_SYMBOL   3'h7

// Oscillator bias codes
`define OSC_BIAS_AUTO    3'h0
`define OSC_BIAS_B01     3'h7
`define OSC_BIAS_B23     3'h5
`define OSC_BIAS_B45     3'h3

`endif

// [modrate_pkg.sv]
// Types used by the modulator rate block; the rate divider uses none of them.
// Assumes modrate_defs.svh is on the include path.
package modrate_pkg;
`include "modrate_defs.svh"

   typedef enum logic [1:0] {
      AXI_IDLE = 2'b00,
      AXI_RESP = 2'b01
   } axi_st_t;

   typedef struct packed {
      logic [1:0] source;
      logic [1:0] level;
   } bias_sel_t;

   typedef struct packed {
      logic [2:0] attenuation_shift;
      logic [1:0] smoothing_step;
      logic osc_run;
      logic osc_ext_drive;
      logic [2:0] osc_bias_band;
   } analog_ctrl_t;

endpackage : modrate_pkg

// [rate_divider.sv]
// Two-stage rate divider: integer prescale then power-of-two postscale.
// Assumes divisor and exponent are stable configuration in the aclk domain.
`timescale 1ns/10ps
`default_nettype none
module rate_divider (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Configuration
   input wire logic [5:0] divisor,
   input wire logic [3:0] exponent,
   // Enable pulses
   output logic pre_tick,
   output logic rate_tick
);
   logic [5:0] pre_cnt_r;
   logic [5:0] pre_cnt_nxt;
   logic [8:0] post_cnt_r;
   logic [8:0] post_cnt_nxt;
   logic [8:0] post_last;
   logic pre_wrap;
   logic post_wrap;

   // A divisor of zero is treated as one so the counter never stalls
   assign pre_wrap = (pre_cnt_r + 6'h01 >= divisor);
   assign pre_cnt_nxt = pre_wrap ? 6'h00 : pre_cnt_r + 6'h01;
   assign post_last = 9'((10'h001 << exponent) - 10'h001);
   assign post_wrap = pre_wrap && (post_cnt_r >= post_last);
   assign post_cnt_nxt = post_wrap ? 9'h000 : (pre_wrap ? post_cnt_r + 9'h001 : post_cnt_r);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_cnt_r <= 6'h00;
         post_cnt_r <= 9'h000;
         pre_tick <= 1'b0;
         rate_tick <= 1'b0;
      end else begin
         pre_cnt_r <= pre_cnt_nxt; // R14
         post_cnt_r <= post_cnt_nxt;
         pre_tick <= pre_wrap;
         rate_tick <= post_wrap; // R14
      end
   end

   // Gap between rate ticks equals the effective divisor times two to the exponent;
   // only periods that ran wholly under one configuration are measured
   logic [15:0] gap_r;
   logic [5:0] div_seen_r;
   logic [3:0] exp_seen_r;
   logic gap_valid_r;
   logic cfg_moved;
   logic [15:0] gap_want;
   assign cfg_moved = (divisor != div_seen_r) || (exponent != exp_seen_r);
   assign gap_want = {10'h000, (divisor == 6'h00) ? 6'h01 : divisor} << exponent;
   always_ff @(posedge aclk) begin
      div_seen_r <= divisor;
      exp_seen_r <= exponent;
      if (!aresetn || rate_tick)
         gap_r <= 16'h0001;
      else
         gap_r <= gap_r + 16'h0001;
      if (!aresetn || cfg_moved)
         gap_valid_r <= 1'b0;
      else if (rate_tick)
         gap_valid_r <= 1'b1;
   end

   AST_RATE_GAP: assert property (@(posedge aclk) disable iff (!aresetn) // R14
      rate_tick && gap_valid_r |-> gap_r == gap_want)
      else $error("rate gap check");
   AST_PRE_ONE: assert property (@(posedge aclk) disable iff (!aresetn) // R14
      rate_tick |-> pre_tick)
      else $error("rate tick without prescale tick");
endmodule : rate_divider
`default_nettype wire

// [modulator_rate_and_test_select.sv]
// Modulator clock, bit-rate enables, ASK spreader, test output select and analog control decode.
// Assumes an AXI4-Lite master on aclk and pin inputs asynchronous to aclk.
//
// Functional notes
// R1 - FSK modulator tick = crystal / divisor; FSK bit tick further / 2^(3+exponent)
// R2 - FSK exponent accepts 0..5, each step doubles the post division
// R3 - ASK bit tick = crystal / divisor / 2^(5+exponent), exponent 0..3
// R4 - PN select 0: spreader emits 01010101 continuously
// R5 - PN select 1: spreader repeats 111101011001000 without gaps
// R6 - Lock indicator off: test select routes ground, dividers, modulator, bandgap, supply, symbol
// R7 - Bias code 000 auto from band; 111,101,011 fixed for band pairs
// R8 - Attenuation codes 0..4 scale deviation by 1, 1/2, 1/4, 1/8, 1/16
// R9 - Smoothing field selects one of four filter steps after attenuator
// R10 - Bypass 0 runs oscillator; bypass 1 lets external differential drive path
// R11 - Amp bias upper bits pick source, lower bits pick level
// R12 - Software sets FSK exponent above zero when biphase coding uses modulator
// R13 - Lock indicator on: lock output follows synthesizer lock status
// R14 - Derived clocks are single-cycle enables from reloading counters
// R15 - Undocumented test code 101 drives lock output low
`timescale 1ns/10ps
`default_nettype none
module modulator_rate_and_test_select
   import modrate_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Analog test sources and lock status, asynchronous
   input wire logic feedback_divider_output,
   input wire logic reference_divider_output,
   input wire logic modulator_output,
   input wire logic bandgap_ok,
   input wire logic digital_supply_ok,
   input wire logic packet_engine_symbol,
   input wire logic synth_locked,
   // Derived clocks and spreader
   output logic fsk_mod_tick,
   output logic fsk_bit_tick,
   output logic ask_bit_tick,
   output logic spread_bit,
   // Lock pin
   output logic lock_output,
   // Analog controls
   output analog_ctrl_t analog_ctrl,
   output bias_sel_t amp_bias,
   output bias_sel_t amp_buffer_bias
);
   function automatic logic [2:0] clamp3(input logic [2:0] v, input logic [2:0] mx);
      clamp3 = (v > mx) ? mx : v;
   endfunction : clamp3

   // Configuration registers
   logic [5:0] fsk_clock_divisor_r;
   logic [2:0] fsk_rate_exponent_r;
   logic [5:0] ask_clock_divisor_r;
   logic [1:0] ask_rate_exponent_r;
   logic ask_pseudo_noise_select_r;
   logic [2:0] test_output_select_r;
   logic lock_indicator_enable_r;
   logic [2:0] oscillator_bias_code_r;
   logic [2:0] oscillator_band_select_r;
   logic oscillator_bypass_r;
   logic [2:0] deviation_attenuation_r;
   logic [1:0] deviation_smoothing_r;
   logic [3:0] amp_bias_code_r;
   logic [3:0] amp_buffer_bias_code_r;

   // Write channel: both address and data held until both present
   logic wr_go;
   logic [7:0] wa;
   logic [31:0] wd;
   logic wr_lane0;
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign wa = s_axi_awaddr;
   assign wd = s_axi_wdata;
   assign wr_lane0 = s_axi_wstrb[0];

   logic wr_hit;
   assign wr_hit = (wa == `OFS_FSK_CLK) || (wa == `OFS_ASK_CLK) || (wa == `OFS_TEST_SEL) ||
                   (wa == `OFS_OSC_CTRL) || (wa == `OFS_DEV_CTRL) || (wa == `OFS_AMP_BIAS);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         s_axi_awready <= wr_go && !s_axi_awready;
         s_axi_wready <= wr_go && !s_axi_awready;
         if (wr_go && !s_axi_awready) begin
            s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
         end
         // The response may only follow the address and data handshakes
         if (s_axi_awready) begin
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   logic wr_take;
   assign wr_take = wr_go && !s_axi_awready && wr_lane0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fsk_clock_divisor_r <= `RST_FSK_DIV;
         fsk_rate_exponent_r <= 3'h0;
         ask_clock_divisor_r <= `RST_ASK_DIV;
         ask_rate_exponent_r <= 2'h0;
         ask_pseudo_noise_select_r <= 1'b0;
         test_output_select_r <= `TOS_GND;
         lock_indicator_enable_r <= 1'b0;
         oscillator_bias_code_r <= `OSC_BIAS_AUTO;
         oscillator_band_select_r <= 3'h0;
         oscillator_bypass_r <= 1'b0;
         deviation_attenuation_r <= 3'h0;
         deviation_smoothing_r <= 2'h0;
         amp_bias_code_r <= 4'h0;
         amp_buffer_bias_code_r <= 4'h0;
      end else if (wr_take) begin
         unique case (wa)
            `OFS_FSK_CLK: begin
               fsk_clock_divisor_r <= wd[5:0]; // R1
               fsk_rate_exponent_r <= clamp3(wd[10:8], `FSK_EXP_MAX); // R2
            end
            `OFS_ASK_CLK: begin
               ask_clock_divisor_r <= wd[5:0]; // R3
               ask_rate_exponent_r <= wd[9:8];
               ask_pseudo_noise_select_r <= wd[16];
            end
            `OFS_TEST_SEL: begin
               test_output_select_r <= wd[2:0];
               lock_indicator_enable_r <= wd[4];
            end
            `OFS_OSC_CTRL: begin
               oscillator_bias_code_r <= wd[2:0];
               oscillator_band_select_r <= wd[6:4];
               oscillator_bypass_r <= wd[7];
            end
            `OFS_DEV_CTRL: begin
               deviation_attenuation_r <= clamp3(wd[2:0], `DEV_ATT_MAX); // R8
               deviation_smoothing_r <= wd[5:4]; // R9
            end
            `OFS_AMP_BIAS: begin
               amp_bias_code_r <= wd[3:0];
               amp_buffer_bias_code_r <= wd[7:4];
            end
            default: begin
            end
         endcase
      end
   end

   // Pin synchronisers for all asynchronous inputs
   logic [6:0] pin_meta_r;
   logic [6:0] pin_sync_r;
   logic [6:0] pin_raw;
   assign pin_raw = {synth_locked, packet_engine_symbol, digital_supply_ok, bandgap_ok,
                     modulator_output, reference_divider_output, feedback_divider_output};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_meta_r <= 7'h00;
         pin_sync_r <= 7'h00;
      end else begin
         pin_meta_r <= pin_raw;
         pin_sync_r <= pin_meta_r;
      end
   end

   // Rate dividers
   logic fsk_pre;
   logic fsk_rate;
   logic ask_pre;
   logic ask_rate;
   logic [3:0] fsk_exp_total;
   logic [3:0] ask_exp_total;
   assign fsk_exp_total = `FSK_EXP_BASE + {1'b0, fsk_rate_exponent_r}; // R1
   assign ask_exp_total = `ASK_EXP_BASE + {2'b00, ask_rate_exponent_r}; // R3

   rate_divider fsk_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .divisor(fsk_clock_divisor_r),
      .exponent(fsk_exp_total),
      .pre_tick(fsk_pre),
      .rate_tick(fsk_rate)
   );
   rate_divider ask_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .divisor(ask_clock_divisor_r),
      .exponent(ask_exp_total),
      .pre_tick(ask_pre),
      .rate_tick(ask_rate)
   );

   // Spreader walks its pattern one chip per ASK bit tick
   logic [3:0] chip_idx_r;
   logic [3:0] chip_last;
   logic chip_bit;
   logic [14:0] pn_word;
   logic [7:0] alt_word;
   assign pn_word = `PN_PATTERN;
   assign alt_word = `ALT_PATTERN;
   assign chip_last = ask_pseudo_noise_select_r ? `PN_LEN : `ALT_LEN;
   // MSB first: alternate pattern starts with 0, PN pattern with 1
   assign chip_bit = ask_pseudo_noise_select_r ? pn_word[4'he - chip_idx_r] // R5
                                               : alt_word[3'(4'h7 - chip_idx_r)]; // R4

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chip_idx_r <= 4'h0;
         spread_bit <= 1'b0;
      end else begin
         if (ask_rate)
            chip_idx_r <= (chip_idx_r >= chip_last) ? 4'h0 : chip_idx_r + 4'h1;
         spread_bit <= chip_bit;
      end
   end

   // Lock pin selection
   logic test_sig;
   logic lock_nxt;
   always_comb begin
      unique case (test_output_select_r) // R6
         `TOS_GND: test_sig = 1'b0;
         `TOS_FB_DIV: test_sig = pin_sync_r[0];
         `TOS_REF_DIV: test_sig = pin_sync_r[1];
         `TOS_MOD_OUT: test_sig = pin_sync_r[2];
         `TOS_BANDGAP: test_sig = pin_sync_r[3];
         `TOS_UNUSED: test_sig = 1'b0; // R15
         `TOS_DIG_SUPPLY: test_sig = pin_sync_r[4];
         `TOS_PKT_SYMBOL: test_sig = pin_sync_r[5];
      endcase
   end
   assign lock_nxt = lock_indicator_enable_r ? pin_sync_r[6] : test_sig; // R13

   // Analog decode
   analog_ctrl_t analog_nxt;
   logic [2:0] bias_band;
   always_comb begin
      unique case (oscillator_bias_code_r) // R7
         `OSC_BIAS_B01: bias_band = 3'h0;
         `OSC_BIAS_B23: bias_band = 3'h2;
         `OSC_BIAS_B45: bias_band = 3'h4;
         default: bias_band = oscillator_band_select_r;
      endcase
   end
   assign analog_nxt = '{attenuation_shift: deviation_attenuation_r, // R8
                         smoothing_step: deviation_smoothing_r, // R9
                         osc_run: !oscillator_bypass_r, // R10
                         osc_ext_drive: oscillator_bypass_r, // R10
                         osc_bias_band: bias_band};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fsk_mod_tick <= 1'b0;
         fsk_bit_tick <= 1'b0;
         ask_bit_tick <= 1'b0;
         lock_output <= 1'b0;
         analog_ctrl <= '{osc_run: 1'b1, default: '0}; // R10
         amp_bias <= '0;
         amp_buffer_bias <= '0;
      end else begin
         fsk_mod_tick <= fsk_pre; // R14
         fsk_bit_tick <= fsk_rate;
         ask_bit_tick <= ask_rate;
         lock_output <= lock_nxt;
         analog_ctrl <= analog_nxt;
         amp_bias <= amp_bias_code_r; // R11
         amp_buffer_bias <= amp_buffer_bias_code_r; // R11
      end
   end

   // Read channel
   logic [31:0] rd_word;
   logic rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      unique case (s_axi_araddr)
         `OFS_FSK_CLK: rd_word = {21'h0, fsk_rate_exponent_r, 2'h0, fsk_clock_divisor_r};
         `OFS_ASK_CLK: rd_word = {15'h0, ask_pseudo_noise_select_r, 6'h0, ask_rate_exponent_r,
                                  2'h0, ask_clock_divisor_r};
         `OFS_TEST_SEL: rd_word = {27'h0, lock_indicator_enable_r, 1'b0, test_output_select_r};
         `OFS_OSC_CTRL: rd_word = {24'h0, oscillator_bypass_r, oscillator_band_select_r,
                                   1'b0, oscillator_bias_code_r};
         `OFS_DEV_CTRL: rd_word = {26'h0, deviation_smoothing_r, 1'b0, deviation_attenuation_r};
         `OFS_AMP_BIAS: rd_word = {24'h0, amp_buffer_bias_code_r, amp_bias_code_r};
         `OFS_STATUS: rd_word = {26'h0, chip_idx_r, pin_sync_r[6], lock_output};
         default: begin
            rd_word = 32'h0;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
         end
         if (s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Assertions
   AST_FSK_EXP_RANGE: assert property (@(posedge aclk) disable iff (!aresetn) // R2
      fsk_rate_exponent_r <= `FSK_EXP_MAX)
      else $error("fsk exponent out of range");
   AST_ATT_RANGE: assert property (@(posedge aclk) disable iff (!aresetn) // R8
      deviation_attenuation_r <= `DEV_ATT_MAX)
      else $error("attenuation out of range");
   AST_LOCK_FOLLOW: assert property (@(posedge aclk) disable iff (!aresetn) // R13
      lock_indicator_enable_r && $stable(lock_indicator_enable_r) |=> lock_output == $past(pin_sync_r[6]))
      else $error("lock output not following lock");
   AST_CODE5_LOW: assert property (@(posedge aclk) disable iff (!aresetn) // R15
      !lock_indicator_enable_r && test_output_select_r == `TOS_UNUSED |=> !lock_output)
      else $error("code 5 not low");
   AST_GND_LOW: assert property (@(posedge aclk) disable iff (!aresetn) // R6
      !lock_indicator_enable_r && test_output_select_r == `TOS_GND |=> !lock_output)
      else $error("ground select not low");
   AST_PN_WRAP: assert property (@(posedge aclk) disable iff (!aresetn) // R5
      ask_pseudo_noise_select_r |-> chip_idx_r <= `PN_LEN || $past(!ask_pseudo_noise_select_r))
      else $error("pn index past end");
   AST_ALT_BIT: assert property (@(posedge aclk) disable iff (!aresetn) // R4
      !ask_pseudo_noise_select_r && chip_idx_r <= `ALT_LEN |=> spread_bit == $past(chip_idx_r[0]))
      else $error("alternate pattern wrong");
   AST_BYPASS: assert property (@(posedge aclk) disable iff (!aresetn) // R10
      analog_ctrl.osc_run != analog_ctrl.osc_ext_drive)
      else $error("bypass decode inconsistent");
   AST_BIAS_FIXED: assert property (@(posedge aclk) disable iff (!aresetn) // R7
      oscillator_bias_code_r == `OSC_BIAS_B45 && $stable(oscillator_bias_code_r) |=> analog_ctrl.osc_bias_band == 3'h4)
      else $error("fixed bias band wrong");
endmodule : modulator_rate_and_test_select
`default_nettype wire

// [tb_modulator_rate_and_test_select.sv]
// Self-checking bench for the modulator rate and test select block.
// Assumes modrate_pkg and its header are compiled first; the bench drives every port itself.
`timescale 1ns/10ps
`default_nettype none
module tb_modulator_rate_and_test_select import modrate_pkg::*;;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic [6:0] src = 7'h00;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic fmt, fbt, abt, sbit, lko;
   analog_ctrl_t actl;
   bias_sel_t ab, abb;
   int failures = 0;
   int check_count = 0;
   logic [31:0] rd;
   logic [1:0] rsp;
   logic [29:0] seq;
   logic [6:0] tmp;
   logic ok, found;
   logic [14:0] pn = 15'b111101011001000;
   int ee;

   modulator_rate_and_test_select dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .feedback_divider_output(src[6]), .reference_divider_output(src[5]),
      .modulator_output(src[4]), .bandgap_ok(src[3]), .digital_supply_ok(src[2]),
      .packet_engine_symbol(src[1]), .synth_locked(src[0]),
      .fsk_mod_tick(fmt), .fsk_bit_tick(fbt), .ask_bit_tick(abt), .spread_bit(sbit),
      .lock_output(lko), .analog_ctrl(actl), .amp_bias(ab), .amp_buffer_bias(abb)
   );

   always #4 aclk = ~aclk;

   task automatic conclude;
      if (failures == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Master holds each valid until its own ready is sampled, and bready until bvalid
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 1000);
      rsp = bresp;
      bready <= 1'b0;
      if (n >= 1000) failures++;
   endtask : wr

   task automatic rd_t(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 1000);
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
      if (n >= 1000) failures++;
   endtask : rd_t

   function automatic logic tk(input int w);
      return (w == 0) ? fmt : (w == 1) ? fbt : abt;
   endfunction : tk

   task automatic wait_tick(input int w);
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (tk(w) !== 1'b1 && n < 5000);
      if (n >= 5000) failures++;
   endtask : wait_tick

   // Skips the first two periods after a change, the first of which may be partial
   task automatic per(input int w, input int exp, input string nm);
      int n;
      wait_tick(w);
      wait_tick(w);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (tk(w) !== 1'b1 && n < 5000);
      chk(nm, 32'(exp), 32'(n));
   endtask : per

   task automatic setsrc(input int c, input int v);
      tmp = {7{~v[0]}};
      if (c != 0 && c != 5) tmp[(c < 5) ? 7 - c : 8 - c] = v[0];
      @(posedge aclk);
      src <= tmp;
      repeat (8) @(posedge aclk);
   endtask : setsrc

   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd_t(8'h00);
      chk("fsk reset", 32'h1, rd);
      rd_t(8'h04);
      chk("ask reset", 32'h1, rd);
      per(0, 1, "mod period at reset");
      // Biphase coding is never enabled here, so an exponent of zero stays legal
      for (int e = 0; e < 8; e++) begin
         wr(8'h00, 32'((e << 8) | 3), 4'hf);
         ee = (e > 5) ? 5 : e;
         rd_t(8'h00);
         chk("fsk reg", 32'((ee << 8) | 3), rd);
         per(0, 3, "mod period");
         per(1, 3 << (3 + ee), "fsk bit period");
      end
      for (int e = 0; e < 4; e++) begin
         wr(8'h04, 32'((e << 8) | 2), 4'hf);
         per(2, 2 << (5 + e), "ask bit period");
      end
      // Chips sampled mid-period so spreader latency does not matter
      for (int p = 0; p < 2; p++) begin
         wr(8'h04, 32'((p << 16) | 1), 4'hf);
         wait_tick(2);
         wait_tick(2);
         for (int i = 0; i < 30; i++) begin
            wait_tick(2);
            repeat (16) @(posedge aclk);
            seq[i] = sbit;
         end
         ok = 1'b1;
         found = 1'b0;
         for (int i = 0; i < 29; i++)
            if ((seq[i] ^ seq[i + 1]) !== 1'b1) ok = 1'b0;
         for (int k = 0; k < 15; k++) begin
            found = 1'b1;
            for (int i = 0; i < 30; i++)
               if (seq[i] !== pn[14 - ((k + i) % 15)]) found = 1'b0;
            if (found) break;
         end
         if (p == 0) chk("alternating chips", 32'h1, 32'(ok));
         else chk("pn chips", 32'h1, 32'(found));
      end
      for (int c = 0; c < 8; c++) begin
         wr(8'h08, 32'(c), 4'hf);
         for (int v = 0; v < 2; v++) begin
            setsrc(c, v);
            chk("test route", (c == 0 || c == 5) ? 32'h0 : 32'(v), 32'(lko));
         end
      end
      wr(8'h08, 32'h13, 4'hf);
      for (int v = 0; v < 2; v++) begin
         @(posedge aclk);
         src <= {~v[0], ~v[0], ~v[0], ~v[0], ~v[0], ~v[0], v[0]};
         repeat (8) @(posedge aclk);
         chk("lock pin", 32'(v), 32'(lko));
         rd_t(8'h18);
         chk("status lock", 32'(v), 32'(rd[0]));
      end
      for (int b = 1; b < 6; b += 4) begin
         wr(8'h0c, 32'(b << 4), 4'hf);
         repeat (4) @(posedge aclk);
         chk("auto bias band", 32'(b), 32'(actl.osc_bias_band));
         chk("osc run", 32'h1, 32'(actl.osc_run));
         chk("ext drive", 32'h0, 32'(actl.osc_ext_drive));
      end
      for (int i = 0; i < 3; i++) begin
         wr(8'h0c, 32'(8'h60 | (7 - 2 * i)), 4'hf);
         repeat (4) @(posedge aclk);
         chk("fixed bias pair", 32'(2 * i), 32'(actl.osc_bias_band));
      end
      wr(8'h0c, 32'h80, 4'hf);
      repeat (4) @(posedge aclk);
      chk("bypass run", 32'h0, 32'(actl.osc_run));
      chk("bypass ext", 32'h1, 32'(actl.osc_ext_drive));
      for (int a = 0; a < 5; a++) begin
         wr(8'h10, 32'((a % 4) << 4 | a), 4'hf);
         repeat (4) @(posedge aclk);
         chk("atten shift", 32'(a), 32'(actl.attenuation_shift));
         chk("smooth step", 32'(a % 4), 32'(actl.smoothing_step));
      end
      wr(8'h10, 32'h7, 4'hf);
      repeat (4) @(posedge aclk);
      chk("atten clamp", 32'h4, 32'(actl.attenuation_shift));
      wr(8'h10, 32'h3, 4'h0);
      rd_t(8'h10);
      chk("no strobe write", 32'h4, 32'(rd[2:0]));
      for (int i = 0; i < 16; i++) begin
         wr(8'h14, 32'({~i[3:0], i[3:0]}), 4'hf);
         repeat (4) @(posedge aclk);
         chk("amp bias", 32'(i[3:0]), 32'(ab));
         chk("amp buffer bias", 32'(4'hf ^ i[3:0]), 32'(abb));
      end
      wr(8'h1c, 32'h1, 4'hf);
      chk("unmapped bresp", 32'h2, 32'(rsp));
      rd_t(8'h1c);
      chk("unmapped rresp", 32'h2, 32'(rsp));
      chk("unmapped rdata", 32'h0, rd);
      conclude;
   end

   initial begin
      #320000;
      failures++;
      conclude;
   end
endmodule : tb_modulator_rate_and_test_select
`default_nettype wire
